/* File: include/arp_pkg.sv */
// Constants and the module geometry type for the aperture and row population registers
package arp_pkg;
	localparam logic [2:0] FUNC_HOST      = 3'h0;
	localparam logic [2:0] FUNC_GFX_PORT  = 3'h1;
	localparam logic [2:0] FUNC_INT_GFX   = 3'h2;
	localparam logic [7:0] OFF_APERTURE_CONTROL = 8'h51;
	localparam logic [7:0] OFF_ROW_POPULATION   = 8'h52;
	localparam logic [7:0] APERTURE_CONTROL_RESET = 8'h00;
	localparam logic [7:0] ROW_POPULATION_RESET   = 8'h00;
	localparam int         BIT_GFX_SELECT   = 0;
	localparam int         BIT_APERTURE_EN  = 1;
	localparam int         BIT_SELECT_LOCK  = 2;
	localparam int         MOD0_LSB         = 0;
	localparam int         MOD1_LSB         = 4;
	localparam logic [7:0] GFX_PORT_REGS_A_LO = 8'h10;
	localparam logic [7:0] GFX_PORT_REGS_A_HI = 8'h13;
	localparam logic [7:0] GFX_PORT_REGS_B_LO = 8'hA0;
	localparam logic [7:0] GFX_PORT_REGS_B_HI = 8'hBF;
	localparam logic [7:0] READ_ALL_ONES  = 8'hFF;
	localparam logic [7:0] READ_ALL_ZEROS = 8'h00;
	localparam int         PORTS = 3;

	// Per-module geometry; back-side fields are zero for single-sided codes
	typedef struct packed {
		logic       present;
		logic       double_sided;
		logic [9:0] capacity_mb;
		logic [3:0] row_bits;
		logic [1:0] bank_front;
		logic [1:0] bank_back;
		logic [3:0] col_front;
		logic [3:0] col_back;
	} arp_geom_t;
endpackage

/* File: src/arp_regs.sv */
// Aperture control and memory row population registers with function visibility control
// Notes on behaviour
// - Aperture control sits at offset 51h of function 0, is 8 bits and resets to zero.
// - Bit 2 is write-once: the first write fixes it until the next reset.
// - While the lock is 1 the graphics select bit 0 is read-only, otherwise writable.
// - Bit 1 enables aperture accesses; while 0 the processor, primary and graphics ports are refused.
// - Select 0 enables the graphics port function and makes function 2 reads return all ones.
// - Select 1 shows function 2, function 1 reads return ones, graphics-port regs in function 0 read zeros.
// - The internal graphics function ignores configuration unless 70h bits 7:6 are nonzero and select is 1.
// - Row population sits at offset 52h, is 8 bits, resets to zero and is writable while unlocked.
// - The whole row population register is read-only once the memory-space lock is set.
// - Bits 7:4 hold the code of module 1 and bits 3:0 that of module 0.
// - Each code decodes to capacity, row, bank and column bits; 0 means empty.
// - Double-sided codes 3, 6 and B carry distinct front and back bank or column widths.
//
// Config port: a strobe is taken at a rising edge and read data follows one cycle later.
// Writes outside function 0 offsets 51h and 52h are dropped; other_rdata covers the rest.
// The lock and size field of 70h live elsewhere and arrive here as plain levels.
// Refused writes are silent: software only sees them by reading back.
// Every output is a flop: read data and aperture gate lag their inputs by one cycle, outputs fed by a written register lag the write by two.
`timescale 1ns/1ps
`default_nettype none
module arp_regs (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Configuration access
	input  wire logic                       cfg_wr,
	input  wire logic                       cfg_rd,
	input  wire logic [2:0]                 cfg_func,
	input  wire logic [7:0]                 cfg_offset,
	input  wire logic [7:0]                 cfg_wdata,
	input  wire logic [7:0]                 other_rdata,
	// Levels from the register at 70h
	input  wire logic                       memory_space_lock,
	input  wire logic [1:0]                 gfx_mem_size,
	// Aperture requests: processor, primary port, graphics port
	input  wire logic [arp_pkg::PORTS-1:0]  aperture_req,
	// Read answer
	output logic      [7:0]                 cfg_rdata,
	output logic                            cfg_rvalid,
	// Function enables and aperture gate
	output logic                            gfx_port_enable,
	output logic                            internal_gfx_enable,
	output logic      [arp_pkg::PORTS-1:0]  aperture_grant,
	output logic      [arp_pkg::PORTS-1:0]  aperture_refuse,
	// Decoded geometry, index 0 for module 0
	output arp_pkg::arp_geom_t [1:0]        module_geom
);
	logic [2:0] aperture_control;
	logic       lock_written;
	logic [7:0] memory_row_population;
	logic       wr_ap;
	logic       wr_row;
	logic [7:0] next_rdata;
	logic       gfx_sel;

	assign gfx_sel = aperture_control[arp_pkg::BIT_GFX_SELECT];
	assign wr_ap  = cfg_wr && cfg_func == arp_pkg::FUNC_HOST
		&& cfg_offset == arp_pkg::OFF_APERTURE_CONTROL;
	assign wr_row = cfg_wr && cfg_func == arp_pkg::FUNC_HOST
		&& cfg_offset == arp_pkg::OFF_ROW_POPULATION;

	// Offsets in function 0 that belong to the graphics port
	// Two windows: the capability block and the port's own control range
	function automatic logic arp_is_gfx_port_reg(input logic [7:0] off);
		arp_is_gfx_port_reg =
			(off >= arp_pkg::GFX_PORT_REGS_A_LO && off <= arp_pkg::GFX_PORT_REGS_A_HI)
			|| (off >= arp_pkg::GFX_PORT_REGS_B_LO && off <= arp_pkg::GFX_PORT_REGS_B_HI);
	endfunction

	// Code 0 and the unsupported code 8 decode as an empty socket
	// Back-side fields stay zero for single-sided codes so the controller can skip that side
	function automatic arp_pkg::arp_geom_t arp_decode(input logic [3:0] code);
		arp_pkg::arp_geom_t g;
		g = '0;
		case (code)
			// 32 MB, both sides alike, one bank bit
			4'h1: g = '{1'b1, 1'b1, 10'd32,  4'd11, 2'd1, 2'd1, 4'd9,  4'd9};
			// 32 MB, front side only
			4'h2: g = '{1'b1, 1'b0, 10'd32,  4'd12, 2'd2, 2'd0, 4'd8,  4'd0};
			// 48 MB, back side has one bank bit fewer
			4'h3: g = '{1'b1, 1'b1, 10'd48,  4'd12, 2'd2, 2'd1, 4'd8,  4'd8};
			// 64 MB, both sides alike
			4'h4: g = '{1'b1, 1'b1, 10'd64,  4'd12, 2'd2, 2'd2, 4'd8,  4'd8};
			// 64 MB, front side only
			4'h5: g = '{1'b1, 1'b0, 10'd64,  4'd12, 2'd2, 2'd0, 4'd9,  4'd0};
			// 96 MB, back side has one column bit fewer
			4'h6: g = '{1'b1, 1'b1, 10'd96,  4'd12, 2'd2, 2'd2, 4'd9,  4'd8};
			// 128 MB, both sides alike
			4'h7: g = '{1'b1, 1'b1, 10'd128, 4'd12, 2'd2, 2'd2, 4'd9,  4'd9};
			// 128 MB, front side only, wide columns
			4'h9: g = '{1'b1, 1'b0, 10'd128, 4'd12, 2'd2, 2'd0, 4'd10, 4'd0};
			// 128 MB, front side only, long rows
			4'hA: g = '{1'b1, 1'b0, 10'd128, 4'd13, 2'd2, 2'd0, 4'd9,  4'd0};
			// 192 MB, back side has one column bit fewer
			4'hB: g = '{1'b1, 1'b1, 10'd192, 4'd12, 2'd2, 2'd2, 4'd10, 4'd9};
			// 256 MB, both sides with wide columns
			4'hC: g = '{1'b1, 1'b1, 10'd256, 4'd12, 2'd2, 2'd2, 4'd10, 4'd10};
			// 256 MB, both sides with long rows
			4'hD: g = '{1'b1, 1'b1, 10'd256, 4'd13, 2'd2, 2'd2, 4'd9,  4'd9};
			// 256 MB, front side only at full width
			4'hE: g = '{1'b1, 1'b0, 10'd256, 4'd13, 2'd2, 2'd0, 4'd10, 4'd0};
			// 512 MB, both sides at full width
			4'hF: g = '{1'b1, 1'b1, 10'd512, 4'd13, 2'd2, 2'd2, 4'd10, 4'd10};
			// Empty socket and the unused code 8
			default: g = '0;
		endcase
		arp_decode = g;
	endfunction

	// Aperture control: only three bits are stored, reserved bits are never kept
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aperture_control <= arp_pkg::APERTURE_CONTROL_RESET[2:0];
			lock_written     <= 1'b0;
		end else if (wr_ap) begin
			aperture_control[arp_pkg::BIT_APERTURE_EN] <=
				cfg_wdata[arp_pkg::BIT_APERTURE_EN];
			if (!aperture_control[arp_pkg::BIT_SELECT_LOCK]) begin
				aperture_control[arp_pkg::BIT_GFX_SELECT] <=
					cfg_wdata[arp_pkg::BIT_GFX_SELECT];
			end
			if (!lock_written) begin
				// First write of the register fixes the lock, whatever value it carries
				aperture_control[arp_pkg::BIT_SELECT_LOCK] <=
					cfg_wdata[arp_pkg::BIT_SELECT_LOCK];
				lock_written <= 1'b1;
			end
		end
	end

	// Row population: frozen once memory space is locked
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memory_row_population <= arp_pkg::ROW_POPULATION_RESET;
		end else if (wr_row && !memory_space_lock) begin
			memory_row_population <= cfg_wdata;
		end
	end

	// Read mux; hidden functions answer ones, graphics-port regs zeros in internal mode
	always_comb begin
		next_rdata = other_rdata;
		if (cfg_func == arp_pkg::FUNC_INT_GFX && !gfx_sel) begin
			next_rdata = arp_pkg::READ_ALL_ONES;
		end else if (cfg_func == arp_pkg::FUNC_GFX_PORT && gfx_sel) begin
			next_rdata = arp_pkg::READ_ALL_ONES;
		end else if (cfg_func == arp_pkg::FUNC_HOST) begin
			if (cfg_offset == arp_pkg::OFF_APERTURE_CONTROL) begin
				next_rdata = {5'h00, aperture_control};
			end else if (cfg_offset == arp_pkg::OFF_ROW_POPULATION) begin
				next_rdata = memory_row_population;
			end else if (gfx_sel && arp_is_gfx_port_reg(cfg_offset)) begin
				next_rdata = arp_pkg::READ_ALL_ZEROS;
			end
		end
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata  <= 8'h00;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= next_rdata;
			end
		end
	end

	// Function enables; internal graphics also needs graphics memory sized
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gfx_port_enable     <= 1'b0;
			internal_gfx_enable <= 1'b0;
		end else begin
			gfx_port_enable     <= !gfx_sel;
			internal_gfx_enable <= gfx_sel && (gfx_mem_size != 2'h0);
		end
	end

	// Aperture gate; the enable is trusted to be set after the table exists
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aperture_grant  <= '0;
			aperture_refuse <= '0;
		end else begin
			aperture_grant  <= aperture_control[arp_pkg::BIT_APERTURE_EN]
				? aperture_req : '0;
			aperture_refuse <= aperture_control[arp_pkg::BIT_APERTURE_EN]
				? '0 : aperture_req;
		end
	end

	// Per-module geometry decode, registered so the controller sees flop outputs
	genvar m;
	generate
		for (m = 0; m < 2; m++) begin : g_mod
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					module_geom[m] <= '0;
				end else begin
					module_geom[m] <= arp_decode(
						memory_row_population[m*4 +: 4]);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* File: test/arp_regs_monitor.sv */
// Port checker for the aperture and row population registers
`timescale 1ns/1ps
`default_nettype none
module arp_regs_monitor (
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire logic                     cfg_wr,
	input wire logic                     cfg_rd,
	input wire logic [2:0]               cfg_func,
	input wire logic [7:0]               cfg_offset,
	input wire logic [7:0]               cfg_wdata,
	input wire logic                     memory_space_lock,
	input wire logic [2:0]               aperture_req,
	input wire logic [7:0]               cfg_rdata,
	input wire logic                     cfg_rvalid,
	input wire logic                     gfx_port_enable,
	input wire logic                     internal_gfx_enable,
	input wire logic [2:0]               aperture_grant,
	input wire logic [2:0]               aperture_refuse,
	input wire arp_pkg::arp_geom_t [1:0] module_geom
);
	// Two quiet edges, because the mode outputs lag a select write by two cycles
	logic [1:0] calm;
	wire        row_wr = cfg_wr && cfg_func == 3'h0 && cfg_offset == 8'h52;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			calm <= 2'h0;
		else
			calm <= {calm[0], !cfg_wr};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_read_answer_due: assert property (cfg_rd |=> cfg_rvalid)
		else $error("read not answered");
	chk_answer_needs_read: assert property (cfg_rvalid |-> $past(cfg_rd))
		else $error("answer without read");
	chk_aperture_gate_split: assert property (1'b1 |=>
		(aperture_grant | aperture_refuse) == $past(aperture_req)) else $error("aperture request lost");
	chk_grant_refuse_apart: assert property ((aperture_grant & aperture_refuse) == 3'h0)
		else $error("grant and refuse together");
	chk_modes_exclusive: assert property (!(gfx_port_enable && internal_gfx_enable))
		else $error("both graphics modes on");
	chk_func2_hidden_ones: assert property (cfg_rd && !cfg_wr && calm == 2'h3 && cfg_func == 3'h2
		&& gfx_port_enable |=> cfg_rdata == 8'hFF) else $error("function 2 visible");
	chk_func1_hidden_ones: assert property (cfg_rd && !cfg_wr && calm == 2'h3 && cfg_func == 3'h1
		&& !gfx_port_enable |=> cfg_rdata == 8'hFF) else $error("function 1 visible");
	chk_locked_rows_hold: assert property (row_wr && memory_space_lock && calm == 2'h3
		|=> ##1 $stable(module_geom)) else $error("locked rows changed");
	chk_empty_code_clears: assert property (row_wr && !memory_space_lock && cfg_wdata == 8'h00
		|=> ##1 module_geom == '0) else $error("empty code not decoded");
	cover property (row_wr && memory_space_lock);
	cover property (cfg_rd && cfg_func == 3'h2);
	cover property (|aperture_grant);
endmodule
bind arp_regs arp_regs_monitor arp_regs_monitor_inst (.clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_func,
	.cfg_offset, .cfg_wdata, .memory_space_lock, .aperture_req, .cfg_rdata, .cfg_rvalid,
	.gfx_port_enable, .internal_gfx_enable, .aperture_grant, .aperture_refuse, .module_geom);
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the aperture and row population registers
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                     clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0;
	logic                     memory_space_lock = 1'b0, cfg_rvalid, gfx_port_enable;
	logic                     internal_gfx_enable;
	logic [2:0]               cfg_func = 3'h0, aperture_req = 3'h0, aperture_grant, aperture_refuse;
	logic [7:0]               cfg_offset = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
	logic [1:0]               gfx_mem_size = 2'h1;
	arp_pkg::arp_geom_t [1:0] module_geom;
	int                       n_errors = 0, total_checks = 0;
	always #5 clk = ~clk;
	// Outside registers answer a fixed pattern so pass-through reads are recognisable
	arp_regs arp_regs_inst (.clk, .rst_n, .cfg_wr, .cfg_rd, .cfg_func, .cfg_offset, .cfg_wdata,
		.other_rdata(8'h5A), .memory_space_lock, .gfx_mem_size, .aperture_req, .cfg_rdata,
		.cfg_rvalid, .gfx_port_enable, .internal_gfx_enable, .aperture_grant, .aperture_refuse,
		.module_geom);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Idle edge after each write lets the mode outputs settle
	task automatic wr(input logic [7:0] off, input logic [7:0] data);
		@(posedge clk);
		cfg_func <= 3'h0;
		cfg_offset <= off;
		cfg_wdata <= data;
		cfg_wr <= 1'b1;
		@(posedge clk);
		cfg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] func, input logic [7:0] off, input logic [7:0] exp);
		@(posedge clk);
		cfg_func <= func;
		cfg_offset <= off;
		cfg_rd <= 1'b1;
		@(posedge clk);
		cfg_rd <= 1'b0;
		#1;
		chk({7'h00, cfg_rvalid}, 8'h01);
		chk(cfg_rdata, exp);
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		do_reset();
		wr(8'h51, 8'h00);
		rd(3'h0, 8'h51, 8'h00);
		rd(3'h0, 8'h52, 8'h00);
		rd(3'h2, 8'h00, 8'hFF);
		rd(3'h1, 8'h10, 8'h5A);
		@(posedge clk);
		aperture_req <= 3'h7;
		repeat (2) @(posedge clk);
		#1 chk({2'h0, aperture_grant, aperture_refuse}, 8'h07);
		wr(8'h51, 8'hFA);
		#1 chk({2'h0, aperture_grant, aperture_refuse}, 8'h38);
		rd(3'h0, 8'h51, 8'h02);
		wr(8'h51, 8'h05);
		rd(3'h0, 8'h51, 8'h01);
		rd(3'h1, 8'h10, 8'hFF);
		rd(3'h0, 8'hA5, 8'h00);
		rd(3'h2, 8'h00, 8'h5A);
		chk({6'h00, gfx_port_enable, internal_gfx_enable}, 8'h01);
		@(posedge clk);
		gfx_mem_size <= 2'h0;
		repeat (2) @(posedge clk);
		#1 chk({6'h00, gfx_port_enable, internal_gfx_enable}, 8'h00);
		do_reset();
		wr(8'h51, 8'h05);
		wr(8'h51, 8'h02);
		rd(3'h0, 8'h51, 8'h07);
		wr(8'h52, 8'h3B);
		rd(3'h0, 8'h52, 8'h3B);
		chk({module_geom[0].col_front, module_geom[0].col_back}, 8'hA9);
		chk({module_geom[1].bank_front, module_geom[1].bank_back,
			module_geom[1].col_front}, 8'h98);
		chk({module_geom[1].row_bits, module_geom[0].row_bits}, 8'hCC);
		chk(module_geom[0].capacity_mb[7:0], 8'hC0);
		@(posedge clk);
		memory_space_lock <= 1'b1;
		wr(8'h52, 8'h00);
		rd(3'h0, 8'h52, 8'h3B);
		@(posedge clk);
		memory_space_lock <= 1'b0;
		wr(8'h52, 8'h00);
		rd(3'h0, 8'h52, 8'h00);
		chk({6'h00, module_geom[1].present, module_geom[0].present}, 8'h00);
		finish_test();
	end
	// Watchdog well beyond the hundred or so cycles the sequence needs
	initial begin
		#20000;
		n_errors++;
		finish_test();
	end
endmodule
`default_nettype wire
